// *** core/rst_sync.sv ***
// Reset release synchroniser: asynchronous assertion, release after two edges.
// Assumes reset_n may change at any time relative to clock.
`timescale 1ns/1ps
`default_nettype none

module rst_sync (
   input  wire logic clock,
   input  wire logic reset_n,
   output logic      rst_n
);

   logic stage;

   // The first stage feeds only the second, so a metastable release never
   // reaches the rest of the design.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stage <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         stage <= 1'b1;
         rst_n <= stage;
      end
   end

endmodule

`default_nettype wire

// *** core/rx_timeout_counter.sv ***
// Transaction time-out down counter of the receive channel.
// Assumes sof_pulse is one cycle wide per frame, one frame per millisecond.
`timescale 1ns/1ps
`default_nettype none

module rx_timeout_counter #(
   parameter int VALUE_W = 5
) (
   input  wire logic               clock,
   input  wire logic               rst_n,
   input  wire logic               arm,
   input  wire logic [VALUE_W-1:0] reload,
   input  wire logic               byte_seen,
   input  wire logic               sof_pulse,
   input  wire logic               restart,
   output logic                    expired
);

   logic [VALUE_W-1:0] count;
   logic               started;

   // Counting waits for the first byte, so an idle line never times out.
   wire running   = arm & started & ~restart;
   wire last_tick = running & sof_pulse & ~byte_seen & (count <= VALUE_W'(1));

   // Reload on each byte, step down on each frame pulse.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count   <= '0;
         started <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= last_tick;
         if (restart || !arm || last_tick) begin
            started <= 1'b0;
         end else if (byte_seen) begin
            started <= 1'b1;
         end
         if (byte_seen) begin
            count <= reload;
         end else if (running && sof_pulse && count != '0) begin
            count <= count - VALUE_W'(1);
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_reload_on_byte: assert property (byte_seen |=> count == $past(reload))
      else $error("time-out counter not reloaded by a byte");

endmodule

`default_nettype wire

// *** core/uart_rx_dma_channel.sv ***
// UART receive DMA channel control with a classic Wishbone register slave.
// Assumes the buffer manager flips buffer_select_bit after each hand-over and
// that the UART offers bytes with a valid/ready pair. One clock, 100 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_dma_cfg.svh"

module uart_rx_dma_channel
   import uart_rx_dma_pkg::*;
#(
   parameter int PACKET_BYTES = 64,
   parameter int TVAL_W       = 5,
   parameter int INDEX_W      = $clog2(PACKET_BYTES),
   parameter int COUNT_W      = $clog2(PACKET_BYTES + 1)
) (
   input  wire logic               clock,
   input  wire logic               reset_n,
   input  wire logic               cyc_i,
   input  wire logic               stb_i,
   input  wire logic               we_i,
   input  wire logic [7:0]         adr_i,
   input  wire logic [3:0]         sel_i,
   input  wire logic [31:0]        dat_i,
   output logic [31:0]             dat_o,
   output logic                    ack_o,
   output logic                    irq,
   input  wire logic               rx_valid,
   input  wire logic [7:0]         rx_data,
   output logic                    rx_ready,
   input  wire logic               rx_error,
   input  wire logic               rx_fifo_full,
   input  wire logic               buffer_select_bit,
   input  wire logic               buf_x_full,
   input  wire logic               buf_y_full,
   input  wire logic               sof_pulse,
   output logic                    buf_wr,
   output logic                    buf_wr_sel,
   output logic [INDEX_W-1:0]      buf_wr_index,
   output logic [7:0]              buf_wr_data,
   output logic                    edb_update,
   output logic [COUNT_W-1:0]      edb_byte_count,
   output logic                    edb_nak,
   output logic                    edb_buffer
);

   logic               rst_n;
   chan_state_t        state;
   chan_state_t        next_state;
   end_cause_t         last_cause;
   logic               run;
   logic               cont_mode;
   logic               ien;
   logic               ten;
   logic [TVAL_W-1:0]  tval;
   logic               tof;
   logic               ovr;
   logic [1:0]         irq_stat;
   logic [1:0]         irq_en;
   logic [COUNT_W-1:0] byte_cnt;
   logic               to_expired;

   // Reset release synchroniser.
   rst_sync u_rst_sync (
      .clock   (clock),
      .reset_n (reset_n),
      .rst_n   (rst_n)
   );

   // Bus decode: one access per request, answered on the following edge.
   // Writes land at the edge where the master samples ack, so a request
   // that is abandoned before its answer never changes a register.
   wire access   = cyc_i & stb_i & ~ack_o;
   wire wr_lane  = cyc_i & stb_i & ack_o & we_i & sel_i[0];
   wire hit_ctrl = adr_i == `OFS_CONTROL;
   wire hit_stat = adr_i == `OFS_STATUS;
   wire hit_ist  = adr_i == `OFS_IRQ_STATUS;
   wire hit_icl  = adr_i == `OFS_IRQ_CLEAR;
   wire hit_ien  = adr_i == `OFS_IRQ_ENABLE;
   wire hit_cnt  = adr_i == `OFS_BYTE_COUNT;
   wire ctrl_wr  = wr_lane & hit_ctrl;
   wire stat_wr  = wr_lane & hit_stat;
   wire icl_wr   = wr_lane & hit_icl;
   wire ien_wr   = wr_lane & hit_ien;

   // Read views of the registers; the select bit mirrors the buffer manager.
   wire [7:0] ctrl_view = {run, ien, cont_mode, buffer_select_bit, 4'h0};
   wire [7:0] stat_view = {ten, tval, tof, ovr};
   wire [7:0] cnt_view  = {edb_nak, (7)'(edb_byte_count)};
   wire [7:0] rd_byte   = hit_ctrl ? ctrl_view :
                          hit_stat ? stat_view :
                          hit_ist  ? {6'h00, irq_stat} :
                          hit_ien  ? {6'h00, irq_en} :
                          hit_cnt  ? cnt_view : 8'h00;

   // Channel activity and the buffer currently named by the manager.
   wire active    = run & cont_mode;
   wire in_rx     = state == st_receive;
   wire sel_full  = buffer_select_bit ? buf_y_full : buf_x_full;

   // Terminations, receiver error first, then overrun, then time-out.
   wire err_end   = in_rx & rx_error;
   wire ovr_end   = in_rx & ~err_end & buf_x_full & buf_y_full & rx_fifo_full;
   wire to_end    = in_rx & ~err_end & ~ovr_end & to_expired;
   wire term      = err_end | ovr_end | to_end;

   // Byte flow: the UART is stalled whenever the target buffer cannot take data.
   assign rx_ready = in_rx & active & ~sel_full & ~term;
   wire take      = rx_valid & rx_ready;
   wire pkt_done  = take & (byte_cnt == COUNT_W'(PACKET_BYTES - 1));
   wire handover  = term | pkt_done;

   // Run is cleared by errors always, by time-out or overrun only when enabled.
   wire hw_clear  = err_end | ((ovr_end | to_end) & ien);
   wire done_ev   = (ovr_end | to_end) & ien & run;
   wire [1:0] irq_set = {term, done_ev};

   // Time-out counter, armed only while enabled and running.
   rx_timeout_counter #(
      .VALUE_W (TVAL_W)
   ) u_timeout (
      .clock     (clock),
      .rst_n     (rst_n),
      .arm       (ten & active & in_rx),
      .reload    (tval),
      .byte_seen (take),
      .sof_pulse (sof_pulse),
      .restart   (handover),
      .expired   (to_expired)
   );

   // Bus answer: ack for one cycle, unmapped reads return zero.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= access;
         dat_o <= {24'h00_0000, rd_byte};
      end
   end

   // Control register; a software write in the same cycle as a hardware
   // clear wins, so a restart issued at that moment is not lost.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run       <= 1'b0;
         cont_mode <= 1'b0;
         ien       <= 1'b0;
      end else if (ctrl_wr) begin
         run       <= dat_i[`CTRL_RUN_BIT];
         cont_mode <= dat_i[`CTRL_CONT_BIT];
         ien       <= dat_i[`CTRL_IEN_BIT];
      end else if (hw_clear) begin
         run       <= 1'b0;
      end
   end

   // Status register: flags are set by hardware and cleared by writing one;
   // a set in the clearing cycle wins.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ten  <= 1'b0;
         tval <= '0;
         tof  <= 1'b0;
         ovr  <= 1'b0;
      end else begin
         if (stat_wr) begin
            ten  <= dat_i[`STAT_TEN_BIT];
            tval <= dat_i[`STAT_TVAL_MSB:`STAT_TVAL_LSB];
         end
         tof <= (ovr_end | to_end) | (tof & ~(stat_wr & dat_i[`STAT_TOF_BIT]));
         ovr <= ovr_end | (ovr & ~(stat_wr & dat_i[`STAT_OVR_BIT]));
      end
   end

   // Interrupt status, clear and enable; the level output follows them.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= `IRQ_RESET;
         irq_en   <= `IRQ_RESET;
      end else begin
         irq_stat <= irq_set | (irq_stat & ~(icl_wr ? dat_i[1:0] : 2'h0));
         if (ien_wr) begin
            irq_en <= dat_i[1:0];
         end
      end
   end

   assign irq = |(irq_stat & irq_en);

   // Sequencing: after each hand-over wait for the manager to flip buffers.
   always_comb begin
      next_state = state;
      case (state)
         st_idle:    if (active) next_state = st_receive;
         st_receive: if (!active && !term) next_state = st_idle;
                     else if (handover) next_state = st_await;
         st_await:   if (buffer_select_bit != edb_buffer) begin
                        next_state = active ? st_receive : st_idle;
                     end
         default:    next_state = st_idle;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state      <= st_idle;
         last_cause <= end_none;
      end else begin
         state <= next_state;
         if (err_end) last_cause <= end_rx_error;
         else if (ovr_end) last_cause <= end_overrun;
         else if (to_end) last_cause <= end_timeout;
      end
   end

   // Byte path into the selected buffer and the running byte count.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         byte_cnt     <= '0;
         buf_wr       <= 1'b0;
         buf_wr_sel   <= 1'b0;
         buf_wr_index <= '0;
         buf_wr_data  <= 8'h00;
      end else begin
         buf_wr <= take;
         if (take) begin
            buf_wr_sel   <= buffer_select_bit;
            buf_wr_index <= INDEX_W'(byte_cnt);
            buf_wr_data  <= rx_data;
         end
         if (handover) byte_cnt <= '0;
         else if (take) byte_cnt <= byte_cnt + COUNT_W'(1);
      end
   end

   // Descriptor update: count and NAK reported at every hand-over.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         edb_update     <= 1'b0;
         edb_byte_count <= '0;
         edb_nak        <= 1'b0;
         edb_buffer     <= 1'b0;
      end else begin
         edb_update <= handover;
         if (handover) begin
            edb_byte_count <= term ? byte_cnt : COUNT_W'(PACKET_BYTES);
            edb_nak        <= 1'b1;
            edb_buffer     <= buffer_select_bit;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_start_on_run: assert property (state == st_idle && active |=> state == st_receive)
      else $error("channel did not start after run was set");

   a_timeout_halts: assert property (to_end |=> tof && edb_update && state == st_await)
      else $error("time-out did not halt and flag the channel");

   a_overrun_flags: assert property (ovr_end |=> ovr && tof)
      else $error("overrun did not set both flags");

   a_error_no_irq: assert property (err_end && !irq_stat[`IRQ_DONE_BIT] |=> !irq_stat[`IRQ_DONE_BIT])
      else $error("receiver error raised the channel interrupt");

   a_error_clears: assert property (err_end && !ctrl_wr |=> !run && edb_update)
      else $error("receiver error did not stop the channel");

   a_keep_running: assert property ((to_end || ovr_end) && !ien && !ctrl_wr |=> run)
      else $error("run cleared with the interrupt disabled");

   a_fall_irq: assert property (done_ev && !ctrl_wr |=> !run ##0 irq_stat[`IRQ_DONE_BIT])
      else $error("run fall did not raise the channel interrupt");

   a_count_nak: assert property (term |=> edb_nak && edb_byte_count == $past(byte_cnt))
      else $error("halt did not report byte count with NAK");

   a_write_select: assert property (take |=> buf_wr && buf_wr_sel == $past(buffer_select_bit))
      else $error("byte written to the wrong buffer");

   a_cause_record: assert property (err_end |=> last_cause == end_rx_error)
      else $error("receiver error halt not recorded as its cause");

endmodule

`default_nettype wire

// *** inc/uart_rx_dma_cfg.svh ***
// Register offsets, field positions, reset values and interrupt bit positions
// of the UART receive DMA channel. Included by bare name; definitions only.
`ifndef UART_RX_DMA_CFG_SVH
`define UART_RX_DMA_CFG_SVH

// Byte offsets on the Wishbone bus, one aligned 32-bit word each.
`define OFS_CONTROL     8'h00
`define OFS_STATUS      8'h04
`define OFS_IRQ_STATUS  8'h08
`define OFS_IRQ_CLEAR   8'h0c
`define OFS_IRQ_ENABLE  8'h10
`define OFS_BYTE_COUNT  8'h14

// Fields of the channel control register.
`define CTRL_SELECT_BIT 4
`define CTRL_CONT_BIT   5
`define CTRL_IEN_BIT    6
`define CTRL_RUN_BIT    7
`define CTRL_RESET      8'h00

// Fields of the channel status register.
`define STAT_OVR_BIT    0
`define STAT_TOF_BIT    1
`define STAT_TVAL_LSB   2
`define STAT_TVAL_MSB   6
`define STAT_TEN_BIT    7
`define STAT_RESET      8'h00

// Bits of the interrupt status, clear and enable registers.
`define IRQ_DONE_BIT    0
`define IRQ_TERM_BIT    1
`define IRQ_RESET       2'h0

`endif

// *** inc/uart_rx_dma_pkg.sv ***
// Types shared by the UART receive DMA channel modules.
// Assumes nothing of its surroundings.
package uart_rx_dma_pkg;

   // Channel sequencing states.
   typedef enum logic [1:0] {st_idle, st_receive, st_await} chan_state_t;

   // Why the last transfer ended.
   typedef enum logic [1:0] {end_none, end_timeout, end_overrun, end_rx_error} end_cause_t;

endpackage

// *** testbench/uart_rx_dma_channel_tb.sv ***
// Self-checking bench of the UART receive DMA channel.
// Assumes the buffer manager model above and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module uart_rx_dma_channel_tb;
   import uart_rx_dma_pkg::*;
   typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_t;
   logic        clock = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        rx_valid = 1'b0, rx_error = 1'b0, rx_fifo_full = 1'b0, sof = 1'b0, stall = 1'b0;
   logic [7:0]  adr = 8'h00, rx_data = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat = 32'h0, q, dat_o;
   logic        ack_o, irq, rx_ready, bsel, xf, yf, buf_wr, wr_sel, upd, nak, ebuf;
   logic [1:0]  idx, last_idx;
   logic [7:0]  wdata, last_dat;
   logic [2:0]  cnt, last_cnt;
   logic        last_sel, last_nak, last_ebuf;
   int          fail_count = 0, n_compared = 0, n_wr = 0, n_upd = 0, u;
   row_t        rows [11] = '{
      '{8'h00, 1'b0, 32'h0, 32'h0}, '{8'h04, 1'b0, 32'h0, 32'h0}, '{8'h14, 1'b0, 32'h0, 32'h0},
      '{8'h00, 1'b1, 32'h60, 32'h0}, '{8'h00, 1'b0, 32'h0, 32'h60},
      '{8'h10, 1'b1, 32'h1, 32'h0}, '{8'h10, 1'b0, 32'h0, 32'h1},
      '{8'h08, 1'b1, 32'h3, 32'h0}, '{8'h08, 1'b0, 32'h0, 32'h0},
      '{8'h20, 1'b1, 32'hff, 32'h0}, '{8'h20, 1'b0, 32'h0, 32'h0}};

   always #5 clock = !clock;

   uart_rx_dma_channel #(.PACKET_BYTES(4)) uut (
      .clock(clock), .reset_n(reset_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .irq(irq), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_ready(rx_ready), .rx_error(rx_error), .rx_fifo_full(rx_fifo_full),
      .buffer_select_bit(bsel), .buf_x_full(xf), .buf_y_full(yf), .sof_pulse(sof),
      .buf_wr(buf_wr), .buf_wr_sel(wr_sel), .buf_wr_index(idx), .buf_wr_data(wdata),
      .edb_update(upd), .edb_byte_count(cnt), .edb_nak(nak), .edb_buffer(ebuf));

   usb_buffer_manager_model partner (
      .clock(clock), .reset_n(reset_n), .edb_update(upd), .edb_buffer(ebuf), .stall(stall),
      .buffer_select_bit(bsel), .buf_x_full(xf), .buf_y_full(yf));

   // Records buffer writes and descriptor updates as they leave the channel.
   always @(posedge clock) begin
      if (buf_wr === 1'b1) begin
         n_wr++;
         {last_sel, last_idx, last_dat} = {wr_sel, idx, wdata};
      end
      if (upd === 1'b1) begin
         n_upd++;
         {last_cnt, last_nak, last_ebuf} = {cnt, nak, ebuf};
      end
   end

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One classic Wishbone cycle; the request holds until ack is sampled high.
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, 4'h1};
      do begin
         @(posedge clock);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) fail_count++;
      q = dat_o;
      {cyc, stb, we} <= 3'h0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(a, 1'b0, 32'h0);
      chk(q, e);
   endtask

   // Offers bytes back to back; the edge after ready is seen is the take edge.
   task automatic send(input int n, input logic [7:0] b);
      int k;
      for (int i = 0; i < n; i++) begin
         k = 0;
         @(posedge clock);
         rx_valid <= 1'b1;
         rx_data <= b + 8'(i);
         do begin
            @(negedge clock);
            k++;
         end while (rx_ready !== 1'b1 && k < 100);
         if (rx_ready !== 1'b1) fail_count++;
      end
      @(posedge clock);
      rx_valid <= 1'b0;
   endtask

   task automatic pulse_sof;
      @(posedge clock);
      sof <= 1'b1;
      @(posedge clock);
      sof <= 1'b0;
   endtask

   // Waits for a descriptor update, then lets the manager flip and ship.
   task automatic wait_upd(input int n0, input logic [2:0] c);
      int k;
      k = 0;
      while (n_upd == n0 && k < 300) begin
         @(posedge clock);
         k++;
      end
      if (n_upd == n0) fail_count++;
      repeat (12) @(posedge clock);
      chk({last_nak, last_cnt}, {1'b1, c});
   endtask

   initial begin
      #300000;
      fail_count++;
      test_done;
   end

   initial begin
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      chk({31'h0, irq}, 32'h0);
      for (int i = 0; i < 11; i++) begin
         if (rows[i].w) wb(rows[i].a, 1'b1, rows[i].d);
         else rd(rows[i].a, rows[i].e);
      end
      // Continuous mode set but no run: nothing may be taken.
      @(posedge clock);
      rx_valid <= 1'b1;
      repeat (6) @(posedge clock);
      rx_valid <= 1'b0;
      chk(n_wr, 0);
      // Run set without continuous mode: the channel must stay idle.
      wb(8'h00, 1'b1, 32'h80);
      @(posedge clock);
      rx_valid <= 1'b1;
      repeat (6) @(posedge clock);
      rx_valid <= 1'b0;
      chk(n_wr, 0);
      $display("test registers done");
      u = n_upd;
      wb(8'h00, 1'b1, 32'he0);
      send(4, 8'h10);
      wait_upd(u, 3'h4);
      chk({21'h0, last_sel, last_idx, last_dat}, {21'h0, 1'b0, 2'h3, 8'h13});
      u = n_upd;
      send(4, 8'h20);
      wait_upd(u, 3'h4);
      chk({last_sel, n_wr[30:0]}, {1'b1, 31'h8});
      chk({31'h0, last_ebuf}, 32'h1);
      rd(8'h00, 32'he0);
      chk({31'h0, irq}, 32'h0);
      $display("test ping-pong done");
      wb(8'h04, 1'b1, 32'h84);
      u = n_upd;
      send(1, 8'h30);
      pulse_sof;
      wait_upd(u, 3'h1);
      chk({31'h0, irq}, 32'h1);
      rd(8'h00, 32'h70);
      rd(8'h04, 32'h86);
      rd(8'h14, 32'h81);
      wb(8'h0c, 1'b1, 32'h3);
      wb(8'h04, 1'b1, 32'h87);
      chk({31'h0, irq}, 32'h0);
      $display("test time-out done");
      wb(8'h00, 1'b1, 32'he0);
      u = n_upd;
      send(1, 8'h31);
      @(posedge clock);
      rx_error <= 1'b1;
      @(posedge clock);
      rx_error <= 1'b0;
      wait_upd(u, 3'h1);
      rd(8'h00, 32'h60);
      chk({31'h0, irq}, 32'h0);
      rd(8'h08, 32'h2);
      rd(8'h04, 32'h84);
      wb(8'h0c, 1'b1, 32'h3);
      $display("test receive error done");
      wb(8'h00, 1'b1, 32'ha0);
      u = n_upd;
      send(1, 8'h32);
      pulse_sof;
      wait_upd(u, 3'h1);
      rd(8'h00, 32'hb0);
      rd(8'h04, 32'h86);
      $display("test interrupt disabled done");
      wb(8'h04, 1'b1, 32'h3);
      stall <= 1'b1;
      send(8, 8'h40);
      repeat (2) @(posedge clock);
      u = n_upd;
      @(posedge clock);
      rx_fifo_full <= 1'b1;
      wait_upd(u, 3'h0);
      rd(8'h04, 32'h3);
      {rx_fifo_full, stall} <= 2'h0;
      $display("test overrun done");
      test_done;
   end
endmodule

`default_nettype wire

// *** testbench/usb_buffer_manager_model.sv ***
// Behavioural model of the USB buffer manager at the channel's far side.
// Assumes edb_update is a one-cycle pulse with edb_buffer valid beside it.
`timescale 1ns/1ps
`default_nettype none

module usb_buffer_manager_model (
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic edb_update,
   input  wire logic edb_buffer,
   input  wire logic stall,
   output logic      buffer_select_bit,
   output logic      buf_x_full,
   output logic      buf_y_full
);
   logic [3:0] ship_wait;

   // A handed-over buffer is marked full and the other one named next; shipping
   // empties the buffers some cycles later, and a stalled host keeps them full.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         buffer_select_bit <= 1'b0;
         buf_x_full        <= 1'b0;
         buf_y_full        <= 1'b0;
         ship_wait         <= 4'h0;
      end else if (edb_update) begin
         buf_x_full        <= buf_x_full | !edb_buffer;
         buf_y_full        <= buf_y_full | edb_buffer;
         buffer_select_bit <= !edb_buffer;
         ship_wait         <= 4'h8;
      end else if (ship_wait != 4'h0) begin
         ship_wait <= ship_wait - 4'h1;
      end else if (!stall) begin
         buf_x_full <= 1'b0;
         buf_y_full <= 1'b0;
      end
   end
endmodule

`default_nettype wire
